// *** dv/core_side_model.sv ***
// core-side model: register file slots that collect the datapath results
`timescale 1ns/1ns
module core_side_model (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] resultLo,
  input wire logic [7:0] resultHi,
  input wire logic resultWrite,
  input wire logic pairWrite,
  input wire logic [15:0] pcOut,
  input wire logic pcLoad,
  output logic [7:0] dstReg,
  output logic [15:0] pairReg,
  output logic [15:0] pcReg
);
  // each strobe lands in its slot one edge later, as a register file would
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dstReg <= 8'h00;
      pairReg <= 16'h0000;
      pcReg <= 16'h0000;
    end else begin
      if (resultWrite) dstReg <= resultLo;
      if (pairWrite) pairReg <= {resultHi, resultLo};
      if (pcLoad) pcReg <= pcOut;
    end
  end
endmodule // core_side_model

// *** dv/tb_top.sv ***
// testbench for the eight-bit alu datapath
`timescale 1ns/1ns
module tb_top;
  import alu_pkg::*;
  logic clk_sys = 1'b0, sys_rst = 1'b1, opValid = 1'b0, regWr = 1'b0, regRd = 1'b0;
  logic [4:0] opCode = 5'h00;
  logic [7:0] dstIn = 8'h00, srcIn = 8'h00, immIn = 8'h00, regWrData = 8'h00, ef = 8'h00;
  logic [15:0] pairIn = 16'h0000, pcIn = 16'h0000;
  logic [JUMP_OFS_W-1:0] jumpOffset = '0;
  logic [5:0] regAddr = 6'h00;
  logic [7:0] regRdData, resultLo, resultHi, flags, coreDst;
  logic resultWrite, pairWrite, pcLoad, busy, done;
  logic [15:0] pcOut, corePair, corePc;
  int fails = 0, checked = 0;
  eight_bit_alu_datapath dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .opValid(opValid),
    .opCode(opCode), .dstIn(dstIn), .srcIn(srcIn), .immIn(immIn), .pairIn(pairIn),
    .jumpOffset(jumpOffset), .pcIn(pcIn), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .resultLo(resultLo),
    .resultHi(resultHi), .resultWrite(resultWrite), .pairWrite(pairWrite), .pcOut(pcOut),
    .pcLoad(pcLoad), .flags(flags), .busy(busy), .done(done));
  core_side_model core (.clk_sys(clk_sys), .sys_rst(sys_rst), .resultLo(resultLo),
    .resultHi(resultHi), .resultWrite(resultWrite), .pairWrite(pairWrite), .pcOut(pcOut),
    .pcLoad(pcLoad), .dstReg(coreDst), .pairReg(corePair), .pcReg(corePc));
  // 125 MHz clock
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_sim();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // expected byte result and status of a one-clock operation
  function automatic logic [15:0] calc(input logic [4:0] op, input logic [7:0] d, s, k, f);
    logic [7:0] a, b, r, nf;
    logic cin, sub, ar, c, h, v;
    a = (op == TWOS_COMPLEMENT_OP) ? 8'h00 : d;
    b = (op inside {SUBTRACT_IMM_OP, SUBTRACT_CARRY_IMM_OP, AND_IMM_OP, OR_IMM_OP,
        SET_BITS_OP, CLEAR_BITS_OP}) ? k : s;
    if (op == TWOS_COMPLEMENT_OP) b = d;
    cin = (op inside {ADD_CARRY_OP, SUBTRACT_CARRY_OP, SUBTRACT_CARRY_IMM_OP}) & f[FLAG_C];
    sub = op inside {SUBTRACT_OP, SUBTRACT_IMM_OP, SUBTRACT_CARRY_OP, SUBTRACT_CARRY_IMM_OP,
        TWOS_COMPLEMENT_OP};
    ar = sub | (op inside {ADD_OP, ADD_CARRY_OP});
    case (op)
      AND_OP, AND_IMM_OP: r = d & b;
      OR_OP, OR_IMM_OP, SET_BITS_OP: r = d | b;
      CLEAR_BITS_OP: r = d & ~b;
      XOR_REGISTERS_OP: r = d ^ b;
      ONES_COMPLEMENT_OP: r = ALL_ONES - d;
      INCREMENT_OP: r = d + 8'h01;
      DECREMENT_OP: r = d - 8'h01;
      ZERO_REGISTER_OP: r = 8'h00;
      FILL_ONES_OP: r = ALL_ONES;
      default: r = d;
    endcase
    if (sub) begin
      r = a - b - cin;
      c = {1'b0, a} < {1'b0, b} + cin;
      h = {1'b0, a[3:0]} < {1'b0, b[3:0]} + cin;
      v = (a[7] != b[7]) && (r[7] != a[7]);
    end else if (ar) begin
      {c, r} = a + b + cin;
      h = ({1'b0, a[3:0]} + b[3:0] + cin) > 5'h0f;
      v = (a[7] == b[7]) && (r[7] != a[7]);
    end
    nf = f;
    nf[FLAG_Z] = r == 8'h00;
    nf[FLAG_N] = r[7];
    if (ar) {nf[FLAG_C], nf[FLAG_V], nf[FLAG_H]} = {c, v, h};
    else nf[FLAG_V] = (op == INCREMENT_OP) ? r == 8'h80 : (op == DECREMENT_OP) && r == 8'h7f;
    if (op == ONES_COMPLEMENT_OP) nf[FLAG_C] = 1'b1;
    if (op == FILL_ONES_OP) nf = f;
    return {r, nf};
  endfunction
  // expected status and pair of a word operation
  function automatic logic [23:0] wcalc(input logic [4:0] op, input logic [15:0] p,
      input logic [5:0] k, input logic [7:0] f);
    logic [16:0] r;
    logic [7:0] nf;
    nf = f;
    r = (op == WORD_ADD_IMM_OP) ? p + k : p - k;
    nf[FLAG_V] = (op == WORD_ADD_IMM_OP) ? ~p[15] & r[15] : p[15] & ~r[15];
    nf[FLAG_C] = r[16];
    nf[FLAG_Z] = r[15:0] == 16'h0000;
    nf[FLAG_N] = r[15];
    nf[FLAG_S] = nf[FLAG_N] ^ nf[FLAG_V];
    return {nf, r[15:0]};
  endfunction
  // one-clock operation: answer stands in the cycle after the take
  task automatic one(input logic [4:0] op, input logic [7:0] d, s, k, mask);
    logic [15:0] e;
    e = calc(op, d, s, k, ef);
    @(posedge clk_sys);
    opValid <= 1'b1;
    opCode <= op;
    dstIn <= d;
    srcIn <= s;
    immIn <= k;
    @(posedge clk_sys);
    opValid <= 1'b0;
    #1;
    chk("strobes", {done, resultWrite, busy, pairWrite, pcLoad}, 5'b11000);
    chk("result", {resultHi, resultLo}, {8'h00, e[15:8]});
    chk("flags", flags & mask, e[7:0] & mask);
    ef = e[7:0];
  endtask
  // two-clock operation; a request held while busy must be ignored
  task automatic two(input logic [4:0] op, input logic [15:0] p, pc, input logic [5:0] k,
      input logic [JUMP_OFS_W-1:0] ofs, input logic [15:0] expv, input logic [7:0] ef2);
    logic w;
    w = op inside {WORD_ADD_IMM_OP, WORD_SUBTRACT_IMM_OP};
    @(posedge clk_sys);
    opValid <= 1'b1;
    opCode <= op;
    pairIn <= p;
    pcIn <= pc;
    immIn <= {2'b11, k};
    jumpOffset <= ofs;
    @(posedge clk_sys);
    opCode <= ADD_OP;
    #1;
    chk("busy", {busy, done}, 2'b10);
    @(posedge clk_sys);
    opValid <= 1'b0;
    #1;
    chk("finish", {done, busy, pairWrite, pcLoad, resultWrite}, {2'b10, w, ~w, 1'b0});
    chk("value", w ? {resultHi, resultLo} : pcOut, expv);
    chk("flags", flags, ef2);
    ef = ef2;
    @(posedge clk_sys);
    #1;
    chk("refused", {done, resultWrite}, 2'b00);
    chk("core", w ? corePair : corePc, expv);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1;
    chk("rdata", regRdData, e);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] dat, input logic [7:0] e);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= dat;
    @(posedge clk_sys);
    regWr <= 1'b0;
    #1;
    chk("status", flags, e);
  endtask
  task automatic test_status();
    chk("reset", {done, busy, resultWrite, pairWrite, pcLoad, flags}, {5'h00, STATUS_RESET});
    rd(STATUS_ADDR, STATUS_RESET);
    wr(6'h3e, 8'hff, STATUS_RESET);
    wr(STATUS_ADDR, 8'hc1, 8'hc1);
    rd(6'h3e, 8'h00);
    rd(STATUS_ADDR, 8'hc1);
    @(posedge clk_sys);
    #1;
    chk("rdata gone", regRdData, 8'h00);
    ef = 8'hc1;
    $display("test status done");
  endtask
  task automatic test_add();
    one(ADD_CARRY_OP, 8'h10, 8'h2f, 8'h00, 8'hff);
    @(posedge clk_sys);
    #1;
    chk("core dst", coreDst, 8'h40);
    one(ADD_OP, 8'h0f, 8'h01, 8'h00, 8'hff);
    one(ADD_OP, 8'h7f, 8'h01, 8'h00, 8'hff);
    one(ADD_OP, 8'hff, 8'h01, 8'h00, 8'hff);
    one(ADD_CARRY_OP, 8'h08, 8'h07, 8'h00, 8'hff);
    $display("test add done");
  endtask
  task automatic test_sub();
    one(SUBTRACT_OP, 8'h10, 8'h01, 8'h55, 8'hff);
    one(SUBTRACT_IMM_OP, 8'h00, 8'h00, 8'h01, 8'hff);
    one(SUBTRACT_CARRY_OP, 8'h05, 8'h04, 8'h00, 8'hff);
    one(SUBTRACT_OP, 8'h00, 8'h01, 8'h00, 8'hff);
    one(SUBTRACT_CARRY_IMM_OP, 8'h80, 8'h33, 8'h00, 8'hff);
    one(SUBTRACT_CARRY_IMM_OP, 8'h40, 8'h00, 8'h41, 8'hff);
    $display("test sub done");
  endtask
  task automatic test_logic();
    logic [4:0] ops [10] = '{AND_OP, AND_IMM_OP, OR_OP, OR_IMM_OP, XOR_REGISTERS_OP,
        SET_BITS_OP, CLEAR_BITS_OP, TEST_VALUE_OP, ZERO_REGISTER_OP, FILL_ONES_OP};
    for (int i = 0; i < 10; i++) begin
      one(ADD_OP, 8'h7f, 8'h01, 8'h00, 8'hff);
      one(ops[i], 8'ha5, 8'h5a, 8'hf0, 8'hff);
    end
    $display("test logic done");
  endtask
  task automatic test_unary();
    one(ONES_COMPLEMENT_OP, 8'h5a, 8'h00, 8'h00, 8'hff);
    one(TWOS_COMPLEMENT_OP, 8'h80, 8'h00, 8'h00, 8'hff);
    one(TWOS_COMPLEMENT_OP, 8'h01, 8'h00, 8'h00, 8'hff);
    one(INCREMENT_OP, 8'h7f, 8'h00, 8'h00, 8'hff);
    one(INCREMENT_OP, 8'hff, 8'h00, 8'h00, 8'hff);
    one(DECREMENT_OP, 8'h80, 8'h00, 8'h00, 8'hff);
    $display("test unary done");
  endtask
  task automatic test_word();
    logic [15:0] ps [5] = '{16'h00ff, 16'h7fff, 16'hffff, 16'h0000, 16'h8000};
    logic [5:0] ks [5] = '{6'h3f, 6'h01, 6'h01, 6'h01, 6'h01};
    logic [4:0] op;
    logic [23:0] e;
    for (int i = 0; i < 5; i++) begin
      op = (i < 3) ? WORD_ADD_IMM_OP : WORD_SUBTRACT_IMM_OP;
      e = wcalc(op, ps[i], ks[i], ef);
      two(op, ps[i], 16'h0000, ks[i], '0, e[15:0], e[23:16]);
    end
    $display("test word done");
  endtask
  task automatic test_jumps();
    logic [JUMP_OFS_W-1:0] ofs [3] = '{12'h005, 12'hfff, 12'h800};
    logic [15:0] t;
    for (int i = 0; i < 3; i++) begin
      t = 16'h1000 + {{(16-JUMP_OFS_W){ofs[i][JUMP_OFS_W-1]}}, ofs[i]} + 16'h0001;
      two(RELATIVE_JUMP_OP, 16'h5a5a, 16'h1000, 6'h00, ofs[i], t, ef);
    end
    two(INDIRECT_JUMP_OP, 16'hbeef, 16'h1000, 6'h00, '0, 16'hbeef, ef);
    $display("test jumps done");
  endtask
  // reset for three cycles, then the scenarios in turn
  initial begin
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    test_status();
    test_add();
    test_sub();
    test_logic();
    test_unary();
    test_word();
    test_jumps();
    end_sim();
  end
  // watchdog well beyond the expected run of about 130 cycles
  initial begin
    #100000;
    fails++;
    end_sim();
  end
endmodule // tb_top

// *** rtl/alu_pkg.sv ***
// shared constants for the eight-bit alu datapath
package alu_pkg;
  // operation codes presented on opCode
  localparam logic [4:0] ADD_OP = 5'h00;
  localparam logic [4:0] ADD_CARRY_OP = 5'h01;
  localparam logic [4:0] WORD_ADD_IMM_OP = 5'h02;
  localparam logic [4:0] SUBTRACT_OP = 5'h03;
  localparam logic [4:0] SUBTRACT_IMM_OP = 5'h04;
  localparam logic [4:0] SUBTRACT_CARRY_OP = 5'h05;
  localparam logic [4:0] SUBTRACT_CARRY_IMM_OP = 5'h06;
  localparam logic [4:0] WORD_SUBTRACT_IMM_OP = 5'h07;
  localparam logic [4:0] AND_OP = 5'h08;
  localparam logic [4:0] AND_IMM_OP = 5'h09;
  localparam logic [4:0] OR_OP = 5'h0a;
  localparam logic [4:0] OR_IMM_OP = 5'h0b;
  localparam logic [4:0] XOR_REGISTERS_OP = 5'h0c;
  localparam logic [4:0] ONES_COMPLEMENT_OP = 5'h0d;
  localparam logic [4:0] TWOS_COMPLEMENT_OP = 5'h0e;
  localparam logic [4:0] SET_BITS_OP = 5'h0f;
  localparam logic [4:0] CLEAR_BITS_OP = 5'h10;
  localparam logic [4:0] INCREMENT_OP = 5'h11;
  localparam logic [4:0] DECREMENT_OP = 5'h12;
  localparam logic [4:0] TEST_VALUE_OP = 5'h13;
  localparam logic [4:0] ZERO_REGISTER_OP = 5'h14;
  localparam logic [4:0] FILL_ONES_OP = 5'h15;
  localparam logic [4:0] RELATIVE_JUMP_OP = 5'h16;
  localparam logic [4:0] INDIRECT_JUMP_OP = 5'h17;
  // status flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  // register port map
  localparam logic [5:0] STATUS_ADDR = 6'h3f;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // operand field widths and constants
  localparam int WORD_IMM_W = 6;
  localparam int JUMP_OFS_W = 12;
  localparam logic [7:0] ALL_ONES = 8'hff;
  localparam logic [7:0] INC_OVERFLOW = 8'h80;
  localparam logic [7:0] DEC_OVERFLOW = 8'h7f;
  // sequencer states; two-clock operations pass through the second state
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SECOND = 1'b1
  } seq_state_e;
endpackage

// *** rtl/eight_bit_alu_datapath.sv ***
// eight-bit alu datapath: arithmetic, logic, unary, word and jump operations
// Operation
// - add and add-with-carry, flags ZCNVH, one clock
// - word add immediate, flags ZCNVS, two clocks
// - subtract immediate, flags ZCNVH, one clock
// - register subtract with carry, ZCNVH, one clock
// - subtract immediate with carry, ZCNVH, one clock
// - word subtract immediate, flags ZCNVS, two clocks
// - and, and immediate, flags ZNV, one clock
// - or, or immediate, flags ZNV, one clock
// - set bits ors mask, flags ZNV
// - clear bits ands inverted mask, flags ZNV
// - test keeps value, sets ZNV, one clock
// - indirect jump loads pointer, no flags, two clocks
`timescale 1ns/1ns
module eight_bit_alu_datapath
  import alu_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic opValid,
  input wire logic [4:0] opCode,
  input wire logic [7:0] dstIn,
  input wire logic [7:0] srcIn,
  input wire logic [7:0] immIn,
  input wire logic [15:0] pairIn,
  input wire logic [JUMP_OFS_W-1:0] jumpOffset,
  input wire logic [15:0] pcIn,
  input wire logic [5:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  output logic [7:0] resultLo,
  output logic [7:0] resultHi,
  output logic resultWrite,
  output logic pairWrite,
  output logic [15:0] pcOut,
  output logic pcLoad,
  output logic [7:0] flags,
  output logic busy,
  output logic done
);

  // add or subtract with carry in; returns {h, v, c, result}
  function automatic logic [10:0] addSub8(input logic [7:0] a, input logic [7:0] b,
                                          input logic cin, input logic sub);
    logic [8:0] s;
    logic [7:0] r;
    logic h;
    logic v;
    s = sub ? ({1'b0, a} - {1'b0, b} - {8'h00, cin}) : ({1'b0, a} + {1'b0, b} + {8'h00, cin});
    r = s[7:0];
    h = sub ? ((~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]))
            : ((a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]));
    v = sub ? ((a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]))
            : ((a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]));
    return {h, v, s[8], r};
  endfunction

  // zero, negative and overflow update for logic and unary results
  function automatic logic [7:0] setZnv(input logic [7:0] f, input logic [7:0] r,
                                        input logic v);
    logic [7:0] o;
    o = f;
    o[FLAG_Z] = (r == 8'h00);
    o[FLAG_N] = r[7];
    o[FLAG_V] = v;
    return o;
  endfunction

  // full arithmetic flag update from an addSub8 result
  function automatic logic [7:0] arithFlags(input logic [7:0] f, input logic [10:0] s);
    logic [7:0] o;
    o = setZnv(f, s[7:0], s[9]);
    o[FLAG_C] = s[8];
    o[FLAG_H] = s[10];
    return o;
  endfunction

  // word flag update; hi7 is the old top bit of the pair
  function automatic logic [7:0] wordFlags(input logic [7:0] f, input logic [15:0] w,
                                           input logic hi7, input logic sub);
    logic [7:0] o;
    o = f;
    o[FLAG_Z] = (w == 16'h0000);
    o[FLAG_N] = w[15];
    o[FLAG_V] = sub ? (hi7 & ~w[15]) : (~hi7 & w[15]);
    o[FLAG_C] = sub ? (w[15] & ~hi7) : (~w[15] & hi7);
    o[FLAG_S] = o[FLAG_N] ^ o[FLAG_V];
    return o;
  endfunction

  seq_state_e state, next_state;
  logic accept;
  logic [10:0] sum;
  logic [16:0] word;
  logic [7:0] calcLo, calcHi, calcFlags;
  logic calcWrite, calcPair, calcJump, calcTwo;
  logic [15:0] calcPc;
  logic [7:0] holdLo, holdHi, holdFlags, next_holdLo, next_holdHi, next_holdFlags;
  logic [15:0] holdPc, next_holdPc;
  logic holdPair, holdJump, next_holdPair, next_holdJump;
  logic [7:0] next_resultLo, next_resultHi, next_flags, next_regRdData;
  logic [15:0] next_pcOut;
  logic next_resultWrite, next_pairWrite, next_pcLoad, next_busy, next_done;
  logic statusHit;

  assign accept = opValid && !busy;
  assign statusHit = (regAddr == STATUS_ADDR);

  // operation decode and result calculation
  always_comb begin
    calcLo = dstIn;
    calcHi = 8'h00;
    calcFlags = flags;
    calcWrite = 1'b1;
    calcPair = 1'b0;
    calcJump = 1'b0;
    calcTwo = 1'b0;
    calcPc = pcIn;
    sum = 11'h000;
    word = 17'h00000;
    unique case (opCode)
      ADD_OP, ADD_CARRY_OP: begin
        sum = addSub8(dstIn, srcIn, (opCode == ADD_CARRY_OP) & flags[FLAG_C], 1'b0);
        calcLo = sum[7:0];
        calcFlags = arithFlags(flags, sum);
      end
      SUBTRACT_OP, SUBTRACT_CARRY_OP: begin
        sum = addSub8(dstIn, srcIn, (opCode == SUBTRACT_CARRY_OP) & flags[FLAG_C], 1'b1);
        calcLo = sum[7:0];
        calcFlags = arithFlags(flags, sum);
      end
      SUBTRACT_IMM_OP: begin
        sum = addSub8(dstIn, immIn, 1'b0, 1'b1);
        calcLo = sum[7:0];
        calcFlags = arithFlags(flags, sum);
      end
      SUBTRACT_CARRY_IMM_OP: begin
        sum = addSub8(dstIn, immIn, flags[FLAG_C], 1'b1);
        calcLo = sum[7:0];
        calcFlags = arithFlags(flags, sum);
      end
      WORD_ADD_IMM_OP, WORD_SUBTRACT_IMM_OP: begin
        // immediate is zero-extended from its short field
        word = (opCode == WORD_SUBTRACT_IMM_OP)
             ? ({1'b0, pairIn} - {11'h000, immIn[WORD_IMM_W-1:0]})
             : ({1'b0, pairIn} + {11'h000, immIn[WORD_IMM_W-1:0]});
        calcLo = word[7:0];
        calcHi = word[15:8];
        calcWrite = 1'b0;
        calcPair = 1'b1;
        calcTwo = 1'b1;
        calcFlags = wordFlags(flags, word[15:0], pairIn[15], opCode == WORD_SUBTRACT_IMM_OP);
      end
      AND_OP, TEST_VALUE_OP: begin
        // test uses the destination as both operands
        calcLo = dstIn & ((opCode == TEST_VALUE_OP) ? dstIn : srcIn);
        calcFlags = setZnv(flags, calcLo, 1'b0);
      end
      AND_IMM_OP, CLEAR_BITS_OP: begin
        calcLo = dstIn & ((opCode == CLEAR_BITS_OP) ? ~immIn : immIn);
        calcFlags = setZnv(flags, calcLo, 1'b0);
      end
      OR_OP: begin
        calcLo = dstIn | srcIn;
        calcFlags = setZnv(flags, calcLo, 1'b0);
      end
      OR_IMM_OP, SET_BITS_OP: begin
        calcLo = dstIn | immIn;
        calcFlags = setZnv(flags, calcLo, 1'b0);
      end
      XOR_REGISTERS_OP, ZERO_REGISTER_OP: begin
        calcLo = dstIn ^ ((opCode == ZERO_REGISTER_OP) ? dstIn : srcIn);
        calcFlags = setZnv(flags, calcLo, 1'b0);
      end
      FILL_ONES_OP: begin
        calcLo = ALL_ONES; // flags untouched
      end
      ONES_COMPLEMENT_OP: begin
        calcLo = ALL_ONES - dstIn;
        calcFlags = setZnv(flags, calcLo, 1'b0);
        calcFlags[FLAG_C] = 1'b1;
      end
      TWOS_COMPLEMENT_OP: begin
        sum = addSub8(8'h00, dstIn, 1'b0, 1'b1);
        calcLo = sum[7:0];
        calcFlags = arithFlags(flags, sum);
      end
      INCREMENT_OP: begin
        calcLo = dstIn + 8'h01;
        calcFlags = setZnv(flags, calcLo, calcLo == INC_OVERFLOW);
      end
      DECREMENT_OP: begin
        calcLo = dstIn - 8'h01;
        calcFlags = setZnv(flags, calcLo, calcLo == DEC_OVERFLOW);
      end
      RELATIVE_JUMP_OP: begin
        calcPc = pcIn + {{(16-JUMP_OFS_W){jumpOffset[JUMP_OFS_W-1]}}, jumpOffset} + 16'h0001;
        calcWrite = 1'b0;
        calcJump = 1'b1;
        calcTwo = 1'b1;
      end
      INDIRECT_JUMP_OP: begin
        calcPc = pairIn;
        calcWrite = 1'b0;
        calcJump = 1'b1;
        calcTwo = 1'b1;
      end
      default: begin
        calcWrite = 1'b0; // unused code: no write strobe, but done pulses and resultLo takes dstIn
      end
    endcase
  end

  // sequencer, output staging and status register port
  always_comb begin
    next_state = state;
    next_busy = 1'b0;
    next_done = 1'b0;
    next_resultWrite = 1'b0;
    next_pairWrite = 1'b0;
    next_pcLoad = 1'b0;
    next_resultLo = resultLo;
    next_resultHi = resultHi;
    next_pcOut = pcOut;
    next_flags = flags;
    next_holdLo = holdLo;
    next_holdHi = holdHi;
    next_holdFlags = holdFlags;
    next_holdPc = holdPc;
    next_holdPair = holdPair;
    next_holdJump = holdJump;
    unique case (state)
      ST_IDLE: begin
        if (accept && calcTwo) begin
          // first clock of word ops and jumps
          next_holdLo = calcLo;
          next_holdHi = calcHi;
          next_holdFlags = calcFlags;
          next_holdPc = calcPc;
          next_holdPair = calcPair;
          next_holdJump = calcJump;
          next_busy = 1'b1;
          next_state = ST_SECOND;
        end else if (accept) begin
          next_resultLo = calcLo; // one-clock ops
          next_resultHi = calcHi;
          next_flags = calcFlags;
          next_resultWrite = calcWrite;
          next_done = 1'b1;
        end
      end
      ST_SECOND: begin
        next_pairWrite = holdPair;
        next_pcLoad = holdJump;
        if (holdJump) begin
          // jumps leave results and flags alone, so a status write in between survives
          next_pcOut = holdPc;
        end else begin
          next_resultLo = holdLo;
          next_resultHi = holdHi;
          next_flags = holdFlags;
        end
        next_done = 1'b1;
        next_state = ST_IDLE;
      end
    endcase
    // a software write of the status register overrides the operation's flag update in the same cycle
    if (regWr && statusHit) begin
      next_flags = regWrData;
    end
    next_regRdData = (regRd && statusHit) ? flags : 8'h00;
  end

  // register stage
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      busy <= 1'b0;
      done <= 1'b0;
      resultWrite <= 1'b0;
      pairWrite <= 1'b0;
      pcLoad <= 1'b0;
      resultLo <= 8'h00;
      resultHi <= 8'h00;
      pcOut <= 16'h0000;
      flags <= STATUS_RESET;
      regRdData <= 8'h00;
      holdLo <= 8'h00;
      holdHi <= 8'h00;
      holdFlags <= STATUS_RESET;
      holdPc <= 16'h0000;
      holdPair <= 1'b0;
      holdJump <= 1'b0;
    end else begin
      state <= next_state;
      busy <= next_busy;
      done <= next_done;
      resultWrite <= next_resultWrite;
      pairWrite <= next_pairWrite;
      pcLoad <= next_pcLoad;
      resultLo <= next_resultLo;
      resultHi <= next_resultHi;
      pcOut <= next_pcOut;
      flags <= next_flags;
      regRdData <= next_regRdData;
      holdLo <= next_holdLo;
      holdHi <= next_holdHi;
      holdFlags <= next_holdFlags;
      holdPc <= next_holdPc;
      holdPair <= next_holdPair;
      holdJump <= next_holdJump;
    end
  end

  // checks: an operation taken with no status write beside it
  logic take;
  assign take = accept && !(regWr && statusHit);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  property p_add_carry;
    take && opCode == ADD_CARRY_OP |=> resultWrite && done
      && resultLo == 8'($past(dstIn) + $past(srcIn) + {7'h00, $past(flags[FLAG_C])});
  endproperty
  a_add_carry: assert property (p_add_carry) else $error("add with carry wrong");

  property p_word_add;
    take && opCode == WORD_ADD_IMM_OP |=> busy && !pairWrite ##1 pairWrite
      && {resultHi, resultLo} == 16'($past(pairIn, 2) + {10'h000, $past(immIn[5:0], 2)});
  endproperty
  a_word_add: assert property (p_word_add) else $error("word add wrong");

  property p_sub_imm;
    take && opCode == SUBTRACT_IMM_OP |=> resultLo == 8'($past(dstIn) - $past(immIn))
      && flags[FLAG_C] == ($past(immIn) > $past(dstIn));
  endproperty
  a_sub_imm: assert property (p_sub_imm) else $error("subtract immediate wrong");

  property p_sub_carry;
    take && opCode == SUBTRACT_CARRY_OP |=>
      flags[FLAG_Z] == (8'($past(dstIn) - $past(srcIn) - {7'h00, $past(flags[FLAG_C])}) == 8'h00);
  endproperty
  a_sub_carry: assert property (p_sub_carry) else $error("subtract carry zero wrong");

  property p_sub_carry_imm;
    take && opCode == SUBTRACT_CARRY_IMM_OP |=>
      resultLo == 8'($past(dstIn) - $past(immIn) - {7'h00, $past(flags[FLAG_C])});
  endproperty
  a_sub_carry_imm: assert property (p_sub_carry_imm) else $error("sub carry imm wrong");

  property p_word_sub;
    take && opCode == WORD_SUBTRACT_IMM_OP ##1 !regWr |=> pairWrite
      && flags[FLAG_S] == (flags[FLAG_N] ^ flags[FLAG_V])
      && flags[FLAG_C] == ({10'h000, $past(immIn[5:0], 2)} > $past(pairIn, 2))
      && {resultHi, resultLo} == 16'($past(pairIn, 2) - {10'h000, $past(immIn[5:0], 2)});
  endproperty
  a_word_sub: assert property (p_word_sub) else $error("word subtract sign wrong");

  property p_and_imm;
    take && opCode == AND_IMM_OP |=> !flags[FLAG_V] && $stable(flags[FLAG_C])
      && resultLo == ($past(dstIn) & $past(immIn));
  endproperty
  a_and_imm: assert property (p_and_imm) else $error("and immediate wrong");

  property p_or_imm;
    take && opCode == OR_IMM_OP |=> resultLo == ($past(dstIn) | $past(immIn))
      && flags[FLAG_N] == resultLo[7];
  endproperty
  a_or_imm: assert property (p_or_imm) else $error("or immediate wrong");

  property p_clear_bits;
    take && opCode == CLEAR_BITS_OP |=> resultLo == ($past(dstIn) & ~$past(immIn));
  endproperty
  a_clear_bits: assert property (p_clear_bits) else $error("clear bits wrong");

  property p_test;
    take && opCode == TEST_VALUE_OP |=> resultLo == $past(dstIn)
      && flags[FLAG_Z] == ($past(dstIn) == 8'h00);
  endproperty
  a_test: assert property (p_test) else $error("test value wrong");

  property p_ind_jump;
    take && opCode == INDIRECT_JUMP_OP ##1 !regWr |=> pcLoad
      && pcOut == $past(pairIn, 2) && flags == $past(flags, 2);
  endproperty
  a_ind_jump: assert property (p_ind_jump) else $error("indirect jump wrong");

  property p_ones;
    take && opCode == ONES_COMPLEMENT_OP |=> flags[FLAG_C] && resultLo == ~$past(dstIn);
  endproperty
  a_ones: assert property (p_ones) else $error("ones complement wrong");

  property p_fill;
    take && opCode == FILL_ONES_OP |=> resultLo == ALL_ONES && $stable(flags);
  endproperty
  a_fill: assert property (p_fill) else $error("fill ones wrong");

  c_add: cover property (take && opCode == ADD_OP ##1 resultWrite);
  c_word: cover property (take && opCode == WORD_ADD_IMM_OP ##2 pairWrite);
  c_jump: cover property (take && opCode == RELATIVE_JUMP_OP ##2 pcLoad);
  c_refused: cover property (busy && opValid);

endmodule // eight_bit_alu_datapath
